/* common/tsrc_params.svh */
`ifndef TSRC_PARAMS_SVH
`define TSRC_PARAMS_SVH

// ----------------------------------------
// Clock and time base
// ----------------------------------------
`define TSRC_CLK_MHZ      100
`define TSRC_TICK_US      125
`define TSRC_TICK_CYCLES  (`TSRC_TICK_US * `TSRC_CLK_MHZ)
`define TSRC_CONV12_MS    140
`define TSRC_CONV12_TICKS (`TSRC_CONV12_MS * 1000 / `TSRC_TICK_US)

// ----------------------------------------
// Sample intervals per rate code, in ms
// ----------------------------------------
`define TSRC_IVL1_MS 64000
`define TSRC_IVL2_MS 32000
`define TSRC_IVL3_MS 16000
`define TSRC_IVL4_MS 4000
`define TSRC_IVL5_MS 1000
`define TSRC_IVL6_MS 250
`define TSRC_IVL7_MS 125
`define TSRC_MS2TICK(ms) ((ms) * 1000 / `TSRC_TICK_US)

// ----------------------------------------
// Byte locations
// ----------------------------------------
`define TSRC_ADDR_TLO 4'h0
`define TSRC_ADDR_THI 4'h1
`define TSRC_ADDR_STS 4'h2
`define TSRC_ADDR_CFG 4'h3
`define TSRC_ADDR_HHI 4'h4
`define TSRC_ADDR_HLO 4'h5
`define TSRC_ADDR_LLO 4'h6
`define TSRC_ADDR_LHI 4'h7
`define TSRC_ADDR_CRC 4'h8

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define TSRC_CFG_FMT   7
`define TSRC_CFG_RESH  6
`define TSRC_CFG_RESL  5
`define TSRC_CFG_MODE  4
`define TSRC_CFG_RSVD  3
`define TSRC_CFG_RATEH 2
`define TSRC_STS_OVER  7
`define TSRC_STS_UNDER 6
`define TSRC_CFG_RST   8'h70
`define TSRC_TEMP_RST  16'h0550
`define TSRC_HI_RST    16'h0800
`define TSRC_LO_RST    16'hFC90
`define TSRC_NORM_MAX  16'h07FF
`define TSRC_NORM_MIN  16'hF800
`define TSRC_EXT_MAX   16'h0FFF
`define TSRC_CRC_POLY  8'h8C

`endif

/* common/tsrc_pkg.sv */
/*
  Types shared by the sensor control block.
  Assumes tsrc_params.svh holds all numeric constants.
*/
package tsrc_pkg;

  typedef enum logic [1:0] {
    TSRC_IDLE,
    TSRC_CONV,
    TSRC_WAIT
  } tsrc_state_t;

  typedef logic [15:0] tsrc_word_t;

endpackage : tsrc_pkg

/* hw/tsrc_sync.sv */
/*
  Two-flop level synchroniser for one pin.
  Assumes the pin is quasi-static relative to clk.
*/
`timescale 1ns/1ps

module tsrc_sync (
  input  wire logic clk,  // System clock
  input  wire logic srst, // Sync reset
  input  wire logic d,    // Asynchronous level
  output logic      q     // Synchronised level
);

  logic meta_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      meta_reg <= 1'b0;
      q        <= 1'b0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule : tsrc_sync

/* hw/tsrc_crc8.sv */
/*
  Check byte over bytes 0..7, shifted LSB first.
  Assumes data is stable; result lags one cycle.
*/
`timescale 1ns/1ps
`include "tsrc_params.svh"

module tsrc_crc8 (
  input  wire logic        clk,  // System clock
  input  wire logic        srst, // Sync reset
  input  wire logic [63:0] data, // Byte 0 in bits 7:0
  output logic      [7:0]  crc   // Registered check byte
);

  logic [7:0] crc_next;

  // ----------------------------------------
  // Reflected x^8+x^5+x^4+1, seed zero
  // ----------------------------------------
  always_comb begin
    crc_next = 8'h00;
    for (int i = 0; i < 64; i++) begin
      if (crc_next[0] ^ data[i]) begin
        crc_next = (crc_next >> 1) ^ `TSRC_CRC_POLY;
      end else begin
        crc_next = crc_next >> 1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      crc <= 8'h00;
    end else begin
      crc <= crc_next;
    end
  end

endmodule : tsrc_crc8

/* hw/tsrc_ctrl.sv */
/*
  Register set and measurement control of a temperature sensor.
  Assumes a byte port from the serial front end, a same-clock
  sample in 1/16 degC, and asynchronous power and strap pins.
*/
`timescale 1ns/1ps
`include "tsrc_params.svh"

module tsrc_ctrl #(
  parameter int TICK_CYCLES = `TSRC_TICK_CYCLES
) (
  input  wire logic        clk,               // System clock
  input  wire logic        srst,              // Sync reset
  input  wire logic [3:0]  reg_addr,          // Byte location
  input  wire logic        reg_rd_en,         // Read strobe
  input  wire logic        reg_wr_en,         // Write strobe
  input  wire logic [7:0]  reg_wdata,         // Write byte
  output logic      [7:0]  reg_rdata,         // Read byte
  input  wire logic        begin_measure_cmd, // Start pulse
  input  wire logic        locate_cmd,        // Locate pulse
  input  wire logic [4:0]  location_code,     // Resistor code
  input  wire logic        location_strap_pin,// Strap pin
  input  wire logic        ext_power_pin,     // External supply
  input  wire logic [15:0] sample_temp,       // Raw 1/16 degC
  output logic             alarm_out,         // Alarm, high
  output logic             conv_busy          // Converting
);

  tsrc_pkg::tsrc_state_t state_reg;
  tsrc_pkg::tsrc_word_t  temp_reg;
  tsrc_pkg::tsrc_word_t  hi_reg;
  tsrc_pkg::tsrc_word_t  lo_reg;
  logic [7:0]  cfg_reg;
  logic [5:0]  loc_reg;
  logic        over_reg;
  logic        under_reg;
  logic        cont_reg;
  logic [13:0] tick_cnt_reg;
  logic        tick_reg;
  logic [10:0] conv_cnt_reg;
  logic [19:0] ivl_cnt_reg;
  logic        ext_sync;
  logic        strap_sync;
  logic [7:0]  crc_byte;
  logic [10:0] conv_ticks;
  logic [19:0] ivl_ticks;
  logic        conv_done;
  logic        ivl_hit;
  logic        start_conv;
  logic        over_now;
  logic        under_now;
  logic        cfg_wr;
  logic [2:0]  rate;
  tsrc_pkg::tsrc_word_t temp_next;

  assign rate   = cfg_reg[`TSRC_CFG_RATEH:0];
  assign cfg_wr = reg_wr_en && (reg_addr == `TSRC_ADDR_CFG);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  tsrc_sync u_sync_pwr (
    .clk  (clk),
    .srst (srst),
    .d    (ext_power_pin),
    .q    (ext_sync)
  );

  tsrc_sync u_sync_strap (
    .clk  (clk),
    .srst (srst),
    .d    (location_strap_pin),
    .q    (strap_sync)
  );

  // ----------------------------------------
  // Time base
  // ----------------------------------------
  // Coarse tick keeps the 64 s interval in a 20-bit counter
  always_ff @(posedge clk) begin
    if (srst || tick_cnt_reg == 14'(TICK_CYCLES - 1)) begin
      tick_cnt_reg <= 14'h0000;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 14'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= (tick_cnt_reg == 14'(TICK_CYCLES - 1));
    end
  end

  // Doubling per resolution step up to 10; 11 is four times 10
  always_comb begin
    unique case (cfg_reg[`TSRC_CFG_RESH:`TSRC_CFG_RESL])
      2'b00: conv_ticks = 11'(`TSRC_CONV12_TICKS >> 4);
      2'b01: conv_ticks = 11'(`TSRC_CONV12_TICKS >> 3);
      2'b10: conv_ticks = 11'(`TSRC_CONV12_TICKS >> 2);
      2'b11: conv_ticks = 11'(`TSRC_CONV12_TICKS);
    endcase
  end

  always_comb begin
    unique case (rate)
      3'h1: ivl_ticks = 20'(`TSRC_MS2TICK(`TSRC_IVL1_MS));
      3'h2: ivl_ticks = 20'(`TSRC_MS2TICK(`TSRC_IVL2_MS));
      3'h3: ivl_ticks = 20'(`TSRC_MS2TICK(`TSRC_IVL3_MS));
      3'h4: ivl_ticks = 20'(`TSRC_MS2TICK(`TSRC_IVL4_MS));
      3'h5: ivl_ticks = 20'(`TSRC_MS2TICK(`TSRC_IVL5_MS));
      3'h6: ivl_ticks = 20'(`TSRC_MS2TICK(`TSRC_IVL6_MS));
      3'h7: ivl_ticks = 20'(`TSRC_MS2TICK(`TSRC_IVL7_MS));
      3'h0: ivl_ticks = 20'hFFFFF;
    endcase
  end

  assign conv_done = (state_reg == tsrc_pkg::TSRC_CONV) && tick_reg
                  && (conv_cnt_reg >= conv_ticks - 11'h001);
  // 12-bit conversions outlast the 125 ms interval
  assign ivl_hit   = (ivl_cnt_reg >= ivl_ticks - 20'h00001);

  // ----------------------------------------
  // Conversion scheduling
  // ----------------------------------------
  assign start_conv = (state_reg == tsrc_pkg::TSRC_IDLE
                       && begin_measure_cmd)
                   || (state_reg == tsrc_pkg::TSRC_WAIT
                       && tick_reg && ivl_hit)
                   || (conv_done && cont_reg && ivl_hit);

  // Continuous only with external supply
  always_ff @(posedge clk) begin
    if (srst || !ext_sync) begin
      cont_reg <= 1'b0;
    end else if (cfg_wr) begin
      cont_reg <= (reg_wdata[`TSRC_CFG_RATEH:0] != 3'h0)
                  && (cont_reg || state_reg == tsrc_pkg::TSRC_IDLE
                      && begin_measure_cmd);
    end else if (state_reg == tsrc_pkg::TSRC_IDLE
                 && begin_measure_cmd) begin
      cont_reg <= (rate != 3'h0);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= tsrc_pkg::TSRC_IDLE;
    end else begin
      unique case (state_reg)
        tsrc_pkg::TSRC_IDLE: begin
          if (start_conv) begin
            state_reg <= tsrc_pkg::TSRC_CONV;
          end
        end
        tsrc_pkg::TSRC_CONV: begin
          if (conv_done) begin
            if (!cont_reg) begin
              state_reg <= tsrc_pkg::TSRC_IDLE;
            end else if (!ivl_hit) begin
              state_reg <= tsrc_pkg::TSRC_WAIT;
            end
          end
        end
        tsrc_pkg::TSRC_WAIT: begin
          if (!cont_reg) begin
            state_reg <= tsrc_pkg::TSRC_IDLE;
          end else if (start_conv) begin
            state_reg <= tsrc_pkg::TSRC_CONV;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst || start_conv) begin
      conv_cnt_reg <= 11'h000;
    end else if (state_reg == tsrc_pkg::TSRC_CONV && tick_reg) begin
      conv_cnt_reg <= conv_cnt_reg + 11'h001;
    end
  end

  // Interval runs from conversion start, saturating
  always_ff @(posedge clk) begin
    if (srst || start_conv) begin
      ivl_cnt_reg <= 20'h00000;
    end else if (tick_reg && ivl_cnt_reg != 20'hFFFFF) begin
      ivl_cnt_reg <= ivl_cnt_reg + 20'h00001;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      conv_busy <= 1'b0;
    end else begin
      conv_busy <= (state_reg == tsrc_pkg::TSRC_CONV);
    end
  end

  // ----------------------------------------
  // Result formatting
  // ----------------------------------------
  // Format taken at the end of conversion
  always_comb begin
    logic signed [15:0] raw;
    raw = $signed(sample_temp);
    unique case (cfg_reg[`TSRC_CFG_RESH:`TSRC_CFG_RESL])
      2'b00: raw = raw & 16'hFFF0;
      2'b01: raw = raw & 16'hFFF8;
      2'b10: raw = raw & 16'hFFFC;
      2'b11: raw = raw;
    endcase
    temp_next = raw;
    if (raw < $signed(`TSRC_NORM_MIN)) begin
      temp_next = `TSRC_NORM_MIN;
    end else if (!cfg_reg[`TSRC_CFG_FMT]
                 && raw > $signed(`TSRC_NORM_MAX)) begin
      temp_next = `TSRC_NORM_MAX;
    end else if (raw > $signed(`TSRC_EXT_MAX)) begin
      temp_next = `TSRC_EXT_MAX;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      temp_reg <= `TSRC_TEMP_RST;
    end else if (conv_done) begin
      temp_reg <= temp_next;
    end
  end

  // ----------------------------------------
  // Limit comparison and alarm
  // ----------------------------------------
  // Limits used as stored, never converted
  assign over_now  = $signed(temp_next) > $signed(hi_reg);
  assign under_now = $signed(temp_next) < $signed(lo_reg);

  always_ff @(posedge clk) begin
    if (srst) begin
      over_reg  <= 1'b0;
      under_reg <= 1'b0;
    end else if (!cfg_reg[`TSRC_CFG_MODE]) begin
      if (conv_done) begin
        over_reg  <= over_now;
        under_reg <= under_now;
      end
    end else if (conv_done && (over_now || under_now)) begin
      // A new violation beats a same-cycle read
      over_reg  <= over_now | (over_reg & ~reg_rd_en);
      under_reg <= under_now | (under_reg & ~reg_rd_en);
    end else if (reg_rd_en) begin
      over_reg  <= 1'b0;
      under_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      alarm_out <= 1'b0;
    end else begin
      alarm_out <= (over_reg | under_reg) & ext_sync;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      loc_reg <= 6'h00;
    end else if (locate_cmd) begin
      loc_reg <= {strap_sync, location_code};
    end
  end

  // ----------------------------------------
  // Writable bytes
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      cfg_reg <= `TSRC_CFG_RST;
    end else if (cfg_wr) begin
      cfg_reg <= reg_wdata;
      cfg_reg[`TSRC_CFG_RSVD] <= 1'b0;
    end
  end

  // Only bytes 3..7 accept writes
  always_ff @(posedge clk) begin
    if (srst) begin
      hi_reg <= `TSRC_HI_RST;
      lo_reg <= `TSRC_LO_RST;
    end else if (reg_wr_en) begin
      unique case (reg_addr)
        `TSRC_ADDR_HHI: hi_reg[15:8] <= reg_wdata;
        `TSRC_ADDR_HLO: hi_reg[7:0]  <= reg_wdata;
        `TSRC_ADDR_LLO: lo_reg[7:0]  <= reg_wdata;
        `TSRC_ADDR_LHI: lo_reg[15:8] <= reg_wdata;
        default: ;
      endcase
    end
  end

  tsrc_crc8 u_crc (
    .clk  (clk),
    .srst (srst),
    .data ({lo_reg[15:8], lo_reg[7:0], hi_reg[7:0], hi_reg[15:8],
            cfg_reg, over_reg, under_reg, loc_reg, temp_reg}),
    .crc  (crc_byte)
  );

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd_en) begin
      unique case (reg_addr)
        `TSRC_ADDR_TLO: reg_rdata <= temp_reg[7:0];
        `TSRC_ADDR_THI: reg_rdata <= temp_reg[15:8];
        `TSRC_ADDR_STS: reg_rdata <= {over_reg, under_reg, loc_reg};
        `TSRC_ADDR_CFG: reg_rdata <= cfg_reg;
        `TSRC_ADDR_HHI: reg_rdata <= hi_reg[15:8];
        `TSRC_ADDR_HLO: reg_rdata <= hi_reg[7:0];
        `TSRC_ADDR_LLO: reg_rdata <= lo_reg[7:0];
        `TSRC_ADDR_LHI: reg_rdata <= lo_reg[15:8];
        `TSRC_ADDR_CRC: reg_rdata <= crc_byte;
        default:        reg_rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_sts_reset;
    @(posedge clk) srst |=> !over_reg && !under_reg && loc_reg == 6'h00;
  endproperty
  a_sts_reset: assert property (p_sts_reset)
    else $error("status not zero after reset");

  property p_cfg_reset;
    @(posedge clk) srst |=> cfg_reg == `TSRC_CFG_RST;
  endproperty
  a_cfg_reset: assert property (p_cfg_reset)
    else $error("config reset value wrong");

  property p_rsvd_zero;
    @(posedge clk) disable iff (srst) !cfg_reg[`TSRC_CFG_RSVD];
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("reserved config bit set");

  property p_sat;
    @(posedge clk) disable iff (srst)
      conv_done && !cfg_reg[`TSRC_CFG_FMT]
      && $signed(sample_temp) > $signed(`TSRC_NORM_MAX)
      |=> temp_reg == `TSRC_NORM_MAX;
  endproperty
  a_sat: assert property (p_sat)
    else $error("normal format did not saturate");

  property p_temp_hold;
    @(posedge clk) disable iff (srst) !conv_done |=> $stable(temp_reg);
  endproperty
  a_temp_hold: assert property (p_temp_hold)
    else $error("temperature changed outside conversion end");

  property p_comp;
    @(posedge clk) disable iff (srst)
      conv_done && !cfg_reg[`TSRC_CFG_MODE]
      |=> over_reg == $past(over_now) && under_reg == $past(under_now);
  endproperty
  a_comp: assert property (p_comp)
    else $error("comparator flags wrong");

  property p_latch_clear;
    @(posedge clk) disable iff (srst)
      reg_rd_en && cfg_reg[`TSRC_CFG_MODE] && !conv_done
      |=> !over_reg && !under_reg ##1 !alarm_out;
  endproperty
  a_latch_clear: assert property (p_latch_clear)
    else $error("read did not release latched alarm");

  property p_bus_power;
    @(posedge clk) disable iff (srst) !ext_sync |=> !alarm_out;
  endproperty
  a_bus_power: assert property (p_bus_power)
    else $error("alarm driven under bus power");

  sequence s_single_end;
    conv_done && !cont_reg;
  endsequence
  property p_single;
    @(posedge clk) disable iff (srst)
      s_single_end |=> state_reg == tsrc_pkg::TSRC_IDLE ##1 !conv_busy;
  endproperty
  a_single: assert property (p_single)
    else $error("single conversion did not return to idle");

  property p_b2b;
    @(posedge clk) disable iff (srst)
      conv_done && cont_reg && ivl_hit
      |=> state_reg == tsrc_pkg::TSRC_CONV && conv_cnt_reg == 11'h000;
  endproperty
  a_b2b: assert property (p_b2b)
    else $error("back-to-back conversion missed");

  property p_loc_hold;
    @(posedge clk) disable iff (srst) !locate_cmd |=> $stable(loc_reg);
  endproperty
  a_loc_hold: assert property (p_loc_hold)
    else $error("location changed without locate");

  property p_rd_thi;
    @(posedge clk) disable iff (srst)
      reg_rd_en && reg_addr == `TSRC_ADDR_THI
      |=> reg_rdata == $past(temp_reg[15:8]);
  endproperty
  a_rd_thi: assert property (p_rd_thi)
    else $error("high temperature byte read wrong");

endmodule : tsrc_ctrl

/* verif/tsrc_mstr.sv */
/*
  Bus-master model driving the byte port of the sensor block.
  Assumes the bench calls wr and rd; drives at falling edges.
*/
`timescale 1ns/1ps

module tsrc_mstr (
  input  wire logic       clk,     // System clock
  input  wire logic       ext_pwr, // External supply present
  output logic      [3:0] addr,    // Byte location
  output logic            rd_en,   // Read strobe
  output logic            wr_en,   // Write strobe
  output logic      [7:0] wdata,   // Write byte
  input  wire logic [7:0] rdata    // Read byte
);
  // Cleared by the bench only to break the rate rule on purpose
  bit keep_rate = 1'b1;

  initial begin
    addr = 4'h0;
    rd_en = 1'b0;
    wr_en = 1'b0;
    wdata = 8'h00;
  end

  // ------
  // Byte cycles
  // ------
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wr_en = 1'b1;
    wdata = (a == 4'h3 && keep_rate && !ext_pwr)
            ? {d[7:3], 3'h0} : d;
    @(negedge clk);
    wr_en = 1'b0;
    // Stale data would hide a missing write strobe check
    wdata = ~d;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    rd_en = 1'b1;
    @(negedge clk);
    rd_en = 1'b0;
    d = rdata;
  endtask : rd
endmodule : tsrc_mstr

/* verif/tb_tsrc_ctrl.sv */
/*
  Self-checking bench for the sensor control block.
  Assumes TICK_CYCLES of 4 and the bus-master model.
*/
`timescale 1ns/1ps

module tb_tsrc_ctrl;
  localparam int TCK = 4;
  logic        clk;
  logic        srst;
  logic        bm;
  logic        loc;
  logic        strap;
  logic        ext;
  logic [4:0]  lcode;
  logic [15:0] samp;
  logic [3:0]  addr;
  logic        rd_en;
  logic        wr_en;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        alarm;
  logic        busy;
  logic [7:0]  b;
  int          n_errors;
  int          checked;
  int          n;
  int          m;
  int          nt;

  tsrc_ctrl #(.TICK_CYCLES(TCK)) tsrc_ctrl_inst (
    .clk(clk), .srst(srst), .reg_addr(addr), .reg_rd_en(rd_en),
    .reg_wr_en(wr_en), .reg_wdata(wdata), .reg_rdata(rdata),
    .begin_measure_cmd(bm), .locate_cmd(loc), .location_code(lcode),
    .location_strap_pin(strap), .ext_power_pin(ext),
    .sample_temp(samp), .alarm_out(alarm), .conv_busy(busy));

  tsrc_mstr tsrc_mstr_inst (
    .clk(clk), .ext_pwr(ext), .addr(addr), .rd_en(rd_en),
    .wr_en(wr_en), .wdata(wdata), .rdata(rdata));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ------
  // Helpers
  // ------
  function automatic logic [7:0] crc8(input logic [63:0] v);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 64; i++) begin
      c = (c[0] ^ v[i]) ? ((c >> 1) ^ 8'h8C) : (c >> 1);
    end
    return c;
  endfunction : crc8

  function automatic logic [15:0] fmt_exp(input logic [15:0] t,
                                          input logic [1:0] r);
    logic signed [15:0] s;
    s = t;
    if (s < -16'sh0800) s = 16'hF800;
    if (s > 16'sh07FF) s = 16'h07FF;
    return s & (16'hFFFF << ((r == 2'h3) ? 0 : 4 - int'(r)));
  endfunction : fmt_exp

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic close_out();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out

  task automatic wait_busy(input logic v, output int k);
    k = 0;
    while (busy !== v) begin
      @(negedge clk);
      k++;
      if (k > 6000) begin
        n_errors++;
        $display("ERROR t=%0t busy wait expired", $time);
        close_out();
      end
    end
  endtask : wait_busy

  task automatic convert(output int k);
    int j;
    @(negedge clk);
    bm = 1'b1;
    @(negedge clk);
    bm = 1'b0;
    wait_busy(1'b1, j);
    wait_busy(1'b0, k);
  endtask : convert

  task automatic w(input logic [3:0] a, input logic [7:0] d);
    tsrc_mstr_inst.wr(a, d);
  endtask : w

  task automatic st(input logic [7:0] e);
    tsrc_mstr_inst.rd(4'h2, b);
    chk({8'h00, b}, {8'h00, e});
  endtask : st

  task automatic chk_temp(input logic [15:0] e);
    logic [7:0] lo;
    tsrc_mstr_inst.rd(4'h0, lo);
    tsrc_mstr_inst.rd(4'h1, b);
    chk({b, lo}, e);
  endtask : chk_temp

  task automatic chk_map(input logic [63:0] v);
    for (int i = 0; i < 9; i++) begin
      tsrc_mstr_inst.rd(i[3:0], b);
      chk({8'h00, b}, {8'h00, (i < 8) ? v[8*i +: 8] : crc8(v)});
    end
  endtask : chk_map

  task automatic idle_chk(input logic v);
    int c;
    c = 0;
    repeat (5000) begin
      @(negedge clk);
      if (busy !== v) c++;
    end
    chk(16'(c), 16'h0000);
  endtask : idle_chk

  // ------
  // Main sequence
  // ------
  initial begin
    srst = 1'b1;
    bm = 1'b0;
    loc = 1'b0;
    strap = 1'b1;
    ext = 1'b1;
    lcode = 5'h00;
    samp = 16'h0000;
    n_errors = 0;
    checked = 0;
    void'($urandom(32'h70f8));
    repeat (5) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    chk_map(64'hFC90_0008_7000_0550);
    tsrc_mstr_inst.rd(4'hB, b);
    chk({8'h00, b}, 16'h0000);
    $display("test reset done");
    w(4'h3, 8'h1F);
    w(4'h0, 8'hAA);
    w(4'h8, 8'h55);
    w(4'h4, 8'h01);
    w(4'h5, 8'h00);
    w(4'h6, 8'h00);
    w(4'h7, 8'h00);
    chk_map(64'h0000_0001_1700_0550);
    chk({15'h0, busy}, 16'h0000);
    $display("test write done");
    for (int r = 0; r < 4; r++) begin
      w(4'h3, {1'b0, r[1:0], 5'h00});
      samp = 16'($urandom_range(0, 3584)) - 16'h0700;
      convert(n);
      nt = ((r == 3) ? 1120 : 70 << r) * TCK;
      chk({15'h0, n inside {[nt - 6 : nt + 6]}}, 16'h0001);
      chk_temp(fmt_exp(samp, r[1:0]));
    end
    $display("test resolution done");
    w(4'h3, 8'h60);
    samp = 16'h0960;
    convert(n);
    chk_temp(16'h07FF);
    w(4'h3, 8'h80);
    chk_temp(16'h07FF);
    convert(n);
    chk_temp(16'h0960);
    $display("test format done");
    w(4'h3, 8'h00);
    samp = 16'h0200;
    convert(n);
    st(8'h80);
    st(8'h80);
    chk({15'h0, alarm}, 16'h0001);
    samp = 16'h0080;
    convert(n);
    st(8'h00);
    chk({15'h0, alarm}, 16'h0000);
    samp = 16'hFFF0;
    convert(n);
    st(8'h40);
    w(4'h3, 8'h10);
    tsrc_mstr_inst.rd(4'h2, b);
    samp = 16'h0200;
    convert(n);
    chk({15'h0, alarm}, 16'h0001);
    tsrc_mstr_inst.rd(4'h5, b);
    st(8'h00);
    chk({15'h0, alarm}, 16'h0000);
    convert(n);
    chk({15'h0, alarm}, 16'h0001);
    st(8'h80);
    ext = 1'b0;
    convert(n);
    chk({15'h0, alarm}, 16'h0000);
    ext = 1'b1;
    $display("test alarm done");
    w(4'h3, 8'h07);
    samp = 16'h0080;
    convert(n);
    wait_busy(1'b1, m);
    chk({15'h0, (n + m) inside {[3990 : 4010]}}, 16'h0001);
    wait_busy(1'b0, m);
    w(4'h3, 8'h00);
    idle_chk(1'b0);
    w(4'h3, 8'h67);
    @(negedge clk);
    bm = 1'b1;
    @(negedge clk);
    bm = 1'b0;
    wait_busy(1'b1, m);
    idle_chk(1'b1);
    w(4'h3, 8'h00);
    wait_busy(1'b0, m);
    tsrc_mstr_inst.keep_rate = 1'b0;
    ext = 1'b0;
    w(4'h3, 8'h07);
    convert(n);
    idle_chk(1'b0);
    tsrc_mstr_inst.keep_rate = 1'b1;
    ext = 1'b1;
    $display("test rate done");
    lcode = 5'($urandom);
    strap = 1'($urandom);
    // Strap needs two edges through its synchroniser
    repeat (3) @(negedge clk);
    loc = 1'b1;
    @(negedge clk);
    loc = 1'b0;
    repeat (3) @(negedge clk);
    st({2'b00, strap, lcode});
    $display("test locate done");
    close_out();
  end
endmodule : tb_tsrc_ctrl
